//--- hdl/iwd_map.svh
`ifndef IWD_MAP_SVH
`define IWD_MAP_SVH

// ***************************************************************
// Port addresses and timing
// ***************************************************************
`define IWD_ADDR_W 16
`define IWD_TIMEOUT_PORT 16'h0443
`define IWD_DISABLE_PORT 16'h0043
`define IWD_CLK_HZ 250000000
`define IWD_TICK_SEC 1
`define IWD_COUNT_ZERO 8'h00
`define IWD_ONE 8'h01
`define IWD_RST_PULSE 8'h10

`endif

//--- hdl/iwd_pkg.sv
package iwd_pkg;
   typedef enum logic [1:0] {
      IWD_IDLE,
      IWD_ARMED,
      IWD_FIRED
   } iwd_state_t;
endpackage

//--- hdl/iwd_tick.sv
`timescale 1ns/1ps
`include "iwd_map.svh"

// ***************************************************************
// One-second tick divider
// ***************************************************************
module iwd_tick #(
   parameter int unsigned TICK_CYCLES = `IWD_CLK_HZ * `IWD_TICK_SEC
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // Control
   input wire logic restart_i,
   output logic tick_o
);
   logic [31:0] cnt;

   // Restart aligns the first second to the arming write
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt <= 32'h0000_0000;
         tick_o <= 1'b0;
      end else if (restart_i) begin
         // The load edge is cycle one of the new second
         cnt <= 32'h0000_0001;
         tick_o <= 1'b0;
      end else if (cnt == TICK_CYCLES - 1) begin
         cnt <= 32'h0000_0000;
         tick_o <= 1'b1;
      end else begin
         cnt <= cnt + 32'h0000_0001;
         tick_o <= 1'b0;
      end
   end
endmodule

//--- hdl/iwd_watchdog.sv
`timescale 1ns/1ps
`include "iwd_map.svh"

// What this block does
// - Nonzero write to timeout port loads and starts, outside a reset request
// - Loaded byte counts whole seconds
// - Rewrite reloads count before expiry
// - Read of disable port stops watchdog
module iwd_watchdog #(
   parameter int unsigned TICK_CYCLES = `IWD_CLK_HZ * `IWD_TICK_SEC
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // I/O port access
   input wire logic [15:0] io_addr_i,
   input wire logic [7:0] io_wdata_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   output logic [7:0] io_rdata_o,
   // Status and reset request
   output logic armed_o,
   output logic [7:0] count_o,
   output logic sys_reset_req_o
);
   // ***************************************************************
   // Decode
   // ***************************************************************
   function automatic logic hit(input logic [15:0] a, input logic [15:0] p);
      hit = (a == p);
   endfunction

   logic load;
   logic stop;
   logic tick;
   logic [7:0] rst_cnt;
   logic accept;
   logic [31:0] gap;
   logic [7:0] req_cycles;
   iwd_pkg::iwd_state_t state;

   assign load = io_wr_i && hit(io_addr_i, `IWD_TIMEOUT_PORT);
   assign stop = io_rd_i && hit(io_addr_i, `IWD_DISABLE_PORT);
   // Loads are dropped while the reset request is out, so the
   // watchdog cannot re-arm under a pulse it has just raised
   assign accept = load && (rst_cnt == `IWD_COUNT_ZERO);

   iwd_tick #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .restart_i(load),
      .tick_o(tick)
   );

   // ***************************************************************
   // State and count
   // ***************************************************************
   // Disable wins over a same-cycle load; read is the stronger intent
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= iwd_pkg::IWD_IDLE;
         count_o <= `IWD_COUNT_ZERO;
      end else if (stop) begin
         state <= iwd_pkg::IWD_IDLE;
         count_o <= `IWD_COUNT_ZERO;
      end else if (accept) begin
         count_o <= io_wdata_i;
         // Zero written is not a valid interval, treat as off
         state <= (io_wdata_i == `IWD_COUNT_ZERO) ?
                  iwd_pkg::IWD_IDLE : iwd_pkg::IWD_ARMED;
      end else begin
         case (state)
            iwd_pkg::IWD_ARMED: begin
               if (tick) begin
                  count_o <= count_o - `IWD_ONE;
                  if (count_o == `IWD_ONE) begin
                     state <= iwd_pkg::IWD_FIRED;
                  end
               end
            end
            iwd_pkg::IWD_FIRED: begin
               if (rst_cnt == `IWD_ONE) begin
                  state <= iwd_pkg::IWD_IDLE;
               end
            end
            default: begin
               state <= iwd_pkg::IWD_IDLE;
            end
         endcase
      end
   end

   // Reset pulse stretched so board reset logic sees it
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_cnt <= `IWD_COUNT_ZERO;
      end else if (state == iwd_pkg::IWD_ARMED && tick &&
                   count_o == `IWD_ONE && !stop && !load) begin
         rst_cnt <= `IWD_RST_PULSE;
      end else if (rst_cnt != `IWD_COUNT_ZERO) begin
         rst_cnt <= rst_cnt - `IWD_ONE;
      end
   end

   assign sys_reset_req_o = (rst_cnt != `IWD_COUNT_ZERO);
   assign armed_o = (state == iwd_pkg::IWD_ARMED);
   // Disable port returns current count; write-only port reads zero
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         io_rdata_o <= `IWD_COUNT_ZERO;
      end else if (stop) begin
         io_rdata_o <= count_o;
      end else if (io_rd_i) begin
         io_rdata_o <= `IWD_COUNT_ZERO;
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   load_arms_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      accept && !stop && io_wdata_i != 8'h00 |=> armed_o &&
      count_o == $past(io_wdata_i))
      else $error("timeout write did not arm");
   read_stops_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      stop |=> !armed_o && count_o == 8'h00)
      else $error("disable read did not stop");
   tick_dec_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      armed_o && tick && !load && !stop |=>
      count_o == $past(count_o) - 8'h01)
      else $error("count did not step on tick");
   hold_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      armed_o && !tick && !load && !stop |=> $stable(count_o))
      else $error("count moved without tick");
   expiry_reset_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      armed_o && tick && count_o == 8'h01 && !load && !stop |=>
      sys_reset_req_o && !armed_o)
      else $error("expiry gave no reset request");
   no_early_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      armed_o |-> !sys_reset_req_o)
      else $error("reset request while armed");

   // ***************************************************************
   // Arming and count
   // ***************************************************************
   load_tick_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      load |=> !tick)
      else $error("load did not restart the second");
   armed_hold_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      armed_o && !stop && !load && !tick |=> armed_o)
      else $error("watchdog dropped without cause");
   count_live_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      armed_o |-> count_o != `IWD_COUNT_ZERO)
      else $error("armed with zero seconds left");
   count_down_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      armed_o && !load |=> count_o <= $past(count_o))
      else $error("count rose without a load");
   zero_write_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      accept && !stop && io_wdata_i == `IWD_COUNT_ZERO |=>
      !armed_o && count_o == `IWD_COUNT_ZERO)
      else $error("zero write left watchdog armed");

   // ***************************************************************
   // Access side effects
   // ***************************************************************
   other_addr_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (io_wr_i || io_rd_i) && !load && !stop && !tick |=>
      $stable(count_o) && $stable(armed_o))
      else $error("foreign port access changed state");
   rdata_count_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      stop |=> io_rdata_o == $past(count_o))
      else $error("disable read lost the count");
   rdata_zero_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      io_rd_i && !stop |=> io_rdata_o == `IWD_COUNT_ZERO)
      else $error("other read returned data");
   rdata_hold_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      !io_rd_i |=> $stable(io_rdata_o))
      else $error("read data moved without a read");

   // ***************************************************************
   // Tick and reset request timing
   // ***************************************************************
   // Cycles since the last tick or prescaler restart
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         gap <= 32'h0000_0000;
      end else if (load || tick) begin
         gap <= 32'h0000_0001;
      end else begin
         gap <= gap + 32'h0000_0001;
      end
   end

   // Length of the reset request so far
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         req_cycles <= `IWD_COUNT_ZERO;
      end else if (sys_reset_req_o) begin
         req_cycles <= req_cycles + `IWD_ONE;
      end else begin
         req_cycles <= `IWD_COUNT_ZERO;
      end
   end

   tick_period_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      tick |-> gap == TICK_CYCLES)
      else $error("second tick at wrong spacing");
   tick_late_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      gap <= TICK_CYCLES)
      else $error("second tick overdue");
   req_len_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      $fell(sys_reset_req_o) |-> req_cycles == `IWD_RST_PULSE)
      else $error("reset request of wrong length");
   req_cause_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      $rose(sys_reset_req_o) |-> $past(armed_o) && $past(tick) &&
      $past(count_o) == `IWD_ONE)
      else $error("reset request without expiry");
   idle_holds_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      !armed_o && !accept |=> !armed_o)
      else $error("watchdog armed without a write");
endmodule

//--- bench/iwd_watchdog_bench.sv
`timescale 1ns/1ps
// ****
// Watchdog bench
// ****
module iwd_watchdog_bench;
   logic mclk_i = 0, reset_n_i = 0, io_wr_i = 0, io_rd_i = 0;
   logic [15:0] io_addr_i = 16'h0000;
   logic [7:0] io_wdata_i = 8'h00, io_rdata_o, count_o, v;
   logic armed_o, sys_reset_req_o;
   logic [17:0] notes[$];
   logic [31:0] lfsr = 32'h0000_ecfa;
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   int miscompares = 0, check_count = 0, n;
   always #2 mclk_i = ~mclk_i;
   // Short tick keeps expiry runs brief
   localparam int TICKS = 10;
   iwd_watchdog #(.TICK_CYCLES(TICKS)) i_dut (.mclk_i(mclk_i),
      .reset_n_i(reset_n_i), .io_addr_i(io_addr_i),
      .io_wdata_i(io_wdata_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
      .io_rdata_o(io_rdata_o), .armed_o(armed_o), .count_o(count_o),
      .sys_reset_req_o(sys_reset_req_o));
   task automatic results();
      if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic tally(input string what, input logic [7:0] got,
         input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      tally("flag", {7'h00, got}, {7'h00, exp});
   endtask
   task automatic chk_count(input logic [7:0] got, input logic [7:0] exp);
      tally("count", got, exp);
   endtask
   task automatic chk_rdata(input logic [7:0] got, input logic [7:0] exp);
      tally("read data", got, exp);
   endtask
   task automatic chk_cycles(input int got, input int exp);
      tally("cycles", 8'(got), 8'(exp));
   endtask
   // Note is {read, armed, count, read data}
   task automatic acc(input logic wr, input logic [15:0] a,
         input logic [7:0] d, input logic [17:0] note);
      notes.push_back(note);
      io_wr_i <= wr;
      io_rd_i <= !wr;
      io_addr_i <= a;
      io_wdata_i <= d;
      @(posedge mclk_i);
      #1;
   endtask
   task automatic idle(input int k);
      io_wr_i <= 0;
      io_rd_i <= 0;
      repeat (k) @(posedge mclk_i);
      #1;
   endtask
   task automatic wait_req(input logic lvl);
      n = 0;
      while (sys_reset_req_o !== lvl && n < 100) begin
         @(posedge mclk_i);
         #1;
         n++;
      end
      if (n >= 100) begin
         miscompares++;
         results();
      end
   endtask
   // Outputs are registered, so checked after the access edge settles
   always @(posedge mclk_i) begin
      logic [17:0] e;
      if (io_wr_i | io_rd_i) begin
         e = notes.pop_front();
         #2;
         chk_flag(armed_o, e[16]);
         chk_count(count_o, e[15:8]);
         if (e[17]) chk_rdata(io_rdata_o, e[7:0]);
      end
   end
   initial begin
      repeat (4) @(posedge mclk_i);
      #1 reset_n_i = 1;
      chk_flag(armed_o, 1'b0);
      chk_flag(sys_reset_req_o, 1'b0);
      chk_count(count_o, 8'h00);
      chk_rdata(io_rdata_o, 8'h00);
      for (int i = 0; i < 6; i++) begin
         lfsr = lfsr_next(lfsr);
         v = (i == 0) ? 8'h01 : (i == 1) ? 8'hff : lfsr[7:0] | 8'h01;
         acc(1, 16'h0443, v, {2'b01, v, 8'h00});
      end
      acc(1, 16'h0444, 8'h05, {2'b01, v, 8'h00});
      acc(0, 16'h0443, 8'h00, {2'b11, v, 8'h00});
      acc(0, 16'h0043, 8'h00, {2'b10, 8'h00, v});
      idle(2);
      acc(1, 16'h0443, 8'h03, {2'b01, 8'h03, 8'h00});
      idle(14);
      chk_count(count_o, 8'h02);
      acc(1, 16'h0443, 8'h03, {2'b01, 8'h03, 8'h00});
      idle(0);
      wait_req(1'b1);
      // Three whole seconds from the reloading write
      chk_cycles(n, 3 * TICKS);
      chk_flag(armed_o, 1'b0);
      chk_count(count_o, 8'h00);
      wait_req(1'b0);
      chk_cycles(n, 16);
      idle(30);
      chk_flag(armed_o, 1'b0);
      lfsr = lfsr_next(lfsr);
      v = lfsr[7:0] | 8'h01;
      acc(1, 16'h0443, v, {2'b01, v, 8'h00});
      // Zero is outside the interval range, so it disarms
      acc(1, 16'h0443, 8'h00, {2'b00, 8'h00, 8'h00});
      acc(1, 16'h0443, 8'h03, {2'b01, 8'h03, 8'h00});
      acc(0, 16'h0043, 8'h00, {2'b10, 8'h00, 8'h03});
      acc(1, 16'h0443, v, {2'b01, v, 8'h00});
      idle(2);
      // Mid-run reset while armed must leave the watchdog off
      reset_n_i = 0;
      repeat (2) @(posedge mclk_i);
      #1 reset_n_i = 1;
      chk_flag(armed_o, 1'b0);
      chk_count(count_o, 8'h00);
      chk_rdata(io_rdata_o, 8'h00);
      idle(40);
      chk_flag(armed_o, 1'b0);
      chk_flag(sys_reset_req_o, 1'b0);
      results();
   end
endmodule
